// file: rtl/usn_ep0_fifo.sv
// usn_ep0_fifo: single-packet bidirectional buffer for control endpoint 0.
// assumes the caller gates rx/tx strobes to packets routed to endpoint 0.
`timescale 1ns/1ps
module usn_ep0_fifo import usn_pkg::*; #(
   parameter int DEPTH = EP0_DEPTH,
   parameter int AW    = $clog2(DEPTH),
   parameter int CW    = AW + 1
) (
   // clock, reset, flush
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic          i_clr,
   input  wire logic          i_clr_done,
   // firmware side
   input  wire logic          i_wr,
   input  wire logic [7:0]    i_wdata,
   input  wire logic          i_rd,
   output logic [7:0]         o_rdata,
   output logic [CW-1:0]      o_count,
   output logic               o_rx_ready,
   output logic               o_tx_ready,
   output logic               o_rx_done,
   output logic               o_tx_done,
   // receive stream
   input  wire logic          i_rx_valid,
   input  wire logic [7:0]    i_rx_data,
   input  wire logic          i_rx_end,
   input  wire logic          i_rx_err,
   // transmit stream
   input  wire logic          i_tx_start,
   input  wire logic          i_tx_next,
   input  wire logic          i_tx_ok,
   input  wire logic          i_tx_err,
   output logic               o_tx_valid,
   output logic [7:0]         o_tx_data,
   output logic               o_tx_last
);
   // ==========================================
   // storage
   logic [7:0]    mem [DEPTH];
   logic [CW-1:0] rd_ptr_q;
   logic [CW-1:0] tx_ptr_q;
   wire  room   = (o_count < CW'(DEPTH));
   wire  put    = (i_rx_valid || (i_wr && !o_tx_valid)) && room;
   wire  [7:0] put_data = i_rx_valid ? i_rx_data : i_wdata;
   wire  rx_good = i_rx_end && !i_rx_err;
   assign o_rdata    = mem[rd_ptr_q[AW-1:0]];
   assign o_rx_ready = (o_count == '0) && !o_rx_done;
   assign o_tx_ready = (o_count != '0) && !o_tx_valid && !o_tx_done;

   // data array; overflow bytes are dropped
   always_ff @(posedge i_clk) begin
      if (put) begin
         mem[o_count[AW-1:0]] <= put_data;
      end
   end

   // one packet of up to DEPTH bytes, either direction
   always_ff @(posedge i_clk) begin
      if (i_rst || i_clr) begin
         o_count    <= '0;
         rd_ptr_q   <= '0;
         tx_ptr_q   <= '0;
         o_tx_valid <= 1'b0;
         o_tx_data  <= 8'h00;
         o_tx_last  <= 1'b0;
         o_rx_done  <= 1'b0;
         o_tx_done  <= 1'b0;
      end else begin
         if (i_rx_end && i_rx_err) begin
            o_count <= '0;
         end else if (i_tx_ok) begin
            o_count <= '0;
         end else if (put) begin
            o_count <= o_count + 1'b1;
         end
         if (i_tx_ok) begin
            rd_ptr_q <= '0;
         end else if (i_rd && rd_ptr_q < o_count) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         // set wins over the firmware clear
         o_rx_done <= rx_good || (o_rx_done && !i_clr_done);
         o_tx_done <= i_tx_ok || (o_tx_done && !i_clr_done);
         if (i_tx_start && o_tx_ready) begin
            o_tx_valid <= 1'b1;
            o_tx_data  <= mem[0];
            o_tx_last  <= (o_count == CW'(1));
            tx_ptr_q   <= CW'(1);
         end else if (i_tx_ok || i_tx_err) begin
            o_tx_valid <= 1'b0;
            o_tx_last  <= 1'b0;
         end else if (i_tx_next && o_tx_valid && !o_tx_last) begin
            o_tx_data <= mem[tx_ptr_q[AW-1:0]];
            o_tx_last <= (tx_ptr_q == o_count - 1'b1);
            tx_ptr_q  <= tx_ptr_q + 1'b1;
         end
      end
   end

   a_ep0_count_cap: assert property (@(posedge i_clk) disable iff (i_rst)
      o_count <= CW'(DEPTH)) else $error("ep0 count above depth");
   a_ep0_err_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_tx_err && !i_tx_ok && !i_clr && !i_rx_valid && !i_rx_end && !i_wr)
      |=> o_count == $past(o_count) && !o_tx_done) else $error("ep0 data lost on tx error");
endmodule

// file: rtl/usn_line_events.sv
// usn_line_events: line condition detector (bus reset, idle, resume, eop).
// assumes i_j / i_se0 are already synchronised to i_clk.
`timescale 1ns/1ps
module usn_line_events import usn_pkg::*; #(
   parameter int IDLE3_CYCLES = IDLE3_CYC,
   parameter int IDLE5_CYCLES = IDLE5_CYC,
   parameter int CW           = 20
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // line state
   input  wire logic i_j,
   input  wire logic i_se0,
   // one-cycle event pulses
   output logic      o_bus_reset,
   output logic      o_idle3,
   output logic      o_idle5,
   output logic      o_resume,
   output logic      o_eop
);
   // ==========================================
   // counters
   logic [CW-1:0] idle_q;
   logic [CW-1:0] se0_q;
   logic [CW-1:0] k_q;
   logic          j_q;
   logic          se0_prev_q;
   wire  is_idle = i_j && !i_se0 && j_q && !se0_prev_q;
   wire  is_k    = !i_j && !i_se0;
   wire  idle_top = (idle_q == CW'(IDLE5_CYCLES));
   wire  se0_top  = (se0_q == CW'(LINE_RST_CYC));
   wire  k_top    = (k_q == CW'(RESUME_CYC));

   // saturating run-length counters; any line change restarts idle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         idle_q     <= '0;
         se0_q      <= '0;
         k_q        <= '0;
         j_q        <= 1'b0;
         se0_prev_q <= 1'b0;
      end else begin
         j_q        <= i_j;
         se0_prev_q <= i_se0;
         idle_q     <= !is_idle ? '0 : (idle_top ? idle_q : idle_q + 1'b1);
         se0_q      <= !i_se0 ? '0 : (se0_top ? se0_q : se0_q + 1'b1);
         k_q        <= !is_k ? '0 : (k_top ? k_q : k_q + 1'b1);
      end
   end

   // events fire once as each run reaches its length
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_bus_reset <= 1'b0;
         o_idle3     <= 1'b0;
         o_idle5     <= 1'b0;
         o_resume    <= 1'b0;
         o_eop       <= 1'b0;
      end else begin
         o_idle3     <= is_idle && (idle_q == CW'(IDLE3_CYCLES - 1));
         o_idle5     <= is_idle && (idle_q == CW'(IDLE5_CYCLES - 1));
         o_bus_reset <= i_se0 && (se0_q == CW'(LINE_RST_CYC - 1));
         o_resume    <= is_k && (k_q == CW'(RESUME_CYC - 1));
         // short se0 then j; a long se0 is a bus reset, not an eop
         o_eop       <= se0_prev_q && !i_se0 && i_j && !se0_top;
      end
   end
endmodule

// file: rtl/usn_node_dispatch.sv
// usn_node_dispatch: node functional state machine, line event register,
// packet address/endpoint dispatch and endpoint-zero packet buffer.
// assumes a packet engine on i_clk presents decoded tokens and byte streams;
// line pins arrive asynchronously. Registers sit on a plain strobe port.
//
// Contract
// - outside running, endpoint state held in reset
// - waking state drives resume K upstream
// - suspended: low power, resume still detected
// - writing 00 enters reset state
// - writing 11 enters suspended state
// - writing 10 enters running state
// - writing 01 enters waking state
// - separate sticky flags for five line events
// - match address, then endpoints in parallel
// - ep0 eight bytes; odd transmit, even receive
// - same direction clash: lower endpoint wins
// - opposite directions with same number independent
// - default address accepted for ep0; no iso
// - ep0 holds one packet of eight bytes
// - ep0 sends on in, retries after error
// - ep0 buffer can be flushed
// - only clean receptions reported, bad ones dropped
// - idle3 flag after 3 ms of no activity
`timescale 1ns/1ps
module usn_node_dispatch import usn_pkg::*; #(
   parameter int IDLE3_CYCLES = IDLE3_CYC,
   parameter int IDLE5_CYCLES = IDLE5_CYC
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // register port
   input  wire logic [4:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   output logic [7:0]      o_reg_rdata,
   // line pins
   input  wire logic       i_line_j,
   input  wire logic       i_line_se0,
   output logic            o_drive_k,
   output logic            o_low_power,
   output logic            o_ep_hold,
   // decoded token
   input  wire logic       i_tok_valid,
   input  wire logic       i_tok_in,
   input  wire logic [6:0] i_tok_addr,
   input  wire logic [3:0] i_tok_ep,
   input  wire logic [6:1] i_ep_ready,
   output logic            o_sel_valid,
   output logic [2:0]      o_sel_ep,
   // ep0 receive stream
   input  wire logic       i_rx_valid,
   input  wire logic [7:0] i_rx_data,
   input  wire logic       i_rx_end,
   input  wire logic       i_rx_err,
   // ep0 transmit stream
   input  wire logic       i_tx_next,
   input  wire logic       i_tx_ok,
   input  wire logic       i_tx_err,
   output logic            o_tx_valid,
   output logic [7:0]      o_tx_data,
   output logic            o_tx_last
);
   // ==========================================
   // pin synchronisers
   logic [1:0] j_sync_q;
   logic [1:0] se0_sync_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         j_sync_q   <= 2'h0;
         se0_sync_q <= 2'h0;
      end else begin
         j_sync_q   <= {j_sync_q[0], i_line_j};
         se0_sync_q <= {se0_sync_q[0], i_line_se0};
      end
   end

   // ==========================================
   // line events
   logic ev_reset;
   logic ev_idle3;
   logic ev_idle5;
   logic ev_resume;
   logic ev_eop;

   // detector keeps running in every state so suspend still sees resume
   usn_line_events #(
      .IDLE3_CYCLES (IDLE3_CYCLES),
      .IDLE5_CYCLES (IDLE5_CYCLES),
      .CW           (20)
   ) u_events (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_j         (j_sync_q[1]),
      .i_se0       (se0_sync_q[1]),
      .o_bus_reset (ev_reset),
      .o_idle3     (ev_idle3),
      .o_idle5     (ev_idle5),
      .o_resume    (ev_resume),
      .o_eop       (ev_eop)
   );

   // ==========================================
   // register decode
   usn_node_t  node_q;
   usn_node_t  node_d;
   logic [1:0] node_code;
   logic [4:0] alternate_event_reg_q;
   logic [6:0] function_address_reg_q;
   logic [7:0] epc_q [NUM_EP];
   logic       ep0_tx_en_q;
   logic       ep0_rx_en_q;
   wire  [4:0] epc_off   = i_reg_addr - ADR_EP_CTRL;
   wire        epc_hit   = (i_reg_addr >= ADR_EP_CTRL) && (epc_off < 5'(NUM_EP));
   wire        wr_node   = i_reg_wr && (i_reg_addr == ADR_NODE_STATE);
   wire        wr_function_address_reg   = i_reg_wr && (i_reg_addr == ADR_FUNC_ADDR);
   wire        wr_cmd    = i_reg_wr && (i_reg_addr == ADR_EP0_CMD);
   wire        wr_data   = i_reg_wr && (i_reg_addr == ADR_EP0_DATA);
   wire        wr_epc    = i_reg_wr && epc_hit;
   wire        rd_alternate_event_reg  = i_reg_rd && (i_reg_addr == ADR_ALT_EVENT);
   wire        rd_stat   = i_reg_rd && (i_reg_addr == ADR_EP0_STAT);
   wire        rd_data   = i_reg_rd && (i_reg_addr == ADR_EP0_DATA);
   wire        running   = (node_q == STATE_RUNNING);
   wire        flush     = wr_cmd && i_reg_wdata[CMD_FLUSH_BIT];
   // resume K we drive ourselves must not flag a resume
   wire        resume_in = ev_resume && (node_q != STATE_WAKING);
   wire  [4:0] ev_set    = {ev_eop, resume_in, ev_idle5, ev_idle3, ev_reset};

   // ==========================================
   // node functional state
   always_comb begin
      node_d = node_q;
      if (wr_node) begin
         unique case (i_reg_wdata[1:0])
            NODE_RESET: node_d = STATE_IN_RESET;
            NODE_SUSP:  node_d = STATE_SUSPENDED;
            NODE_RUN:   node_d = STATE_RUNNING;
            NODE_WAKE:  node_d = STATE_WAKING;
         endcase
      end
   end

   // state as seen in the node state field
   always_comb begin
      unique case (node_q)
         STATE_IN_RESET:  node_code = NODE_RESET;
         STATE_RUNNING:   node_code = NODE_RUN;
         STATE_SUSPENDED: node_code = NODE_SUSP;
         STATE_WAKING:    node_code = NODE_WAKE;
         default:         node_code = NODE_RESET;
      endcase
   end

   // transitions are firmware-driven only; line events merely report
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         node_q      <= STATE_IN_RESET;
         o_drive_k   <= 1'b0;
         o_low_power <= 1'b0;
         o_ep_hold   <= 1'b1;
      end else begin
         node_q      <= node_d;
         o_drive_k   <= (node_q == STATE_WAKING);
         o_low_power <= (node_q == STATE_SUSPENDED);
         o_ep_hold   <= !running;
      end
   end

   // sticky event flags, cleared by reading; an event in the read cycle survives
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         alternate_event_reg_q <= 5'h00;
      end else begin
         alternate_event_reg_q <= ev_set | (rd_alternate_event_reg ? 5'h00 : alternate_event_reg_q);
      end
   end

   // ==========================================
   // endpoint configuration, held cleared outside running
   always_ff @(posedge i_clk) begin
      if (i_rst || !running) begin
         function_address_reg_q      <= FUNCTION_ADDRESS_REG_RST;
         ep0_tx_en_q <= 1'b0;
         ep0_rx_en_q <= 1'b0;
         for (int e = 0; e < NUM_EP; e++) begin
            epc_q[e] <= EPC_RST;
         end
      end else begin
         if (wr_function_address_reg) begin
            function_address_reg_q <= i_reg_wdata[6:0];
         end
         if (wr_cmd) begin
            ep0_tx_en_q <= i_reg_wdata[CMD_TX_BIT];
            ep0_rx_en_q <= i_reg_wdata[CMD_RX_BIT];
         end
         if (wr_epc) begin
            epc_q[epc_off[2:0]] <= i_reg_wdata;
         end
      end
   end

   // ==========================================
   // address and endpoint dispatch
   logic [3:0] ep0_count;
   logic       ep0_rx_ready;
   logic       ep0_tx_ready;
   logic       ep0_rx_done;
   logic       ep0_tx_done;
   logic [7:0] ep0_rdata;
   logic [NUM_EP-1:0] elig;
   logic [2:0] pick;
   logic       pick_hit;
   logic       ep0_rx_act_q;
   logic       ep0_tx_act_q;
   wire        addr_hit = (i_tok_addr == function_address_reg_q);
   wire        def_hit  = (i_tok_addr == 7'h00) && epc_q[0][EPC_DEF_BIT];
   wire  [NUM_EP-1:0] ready_v = {i_ep_ready, i_tok_in ? ep0_tx_ready : ep0_rx_ready};

   // every endpoint compares at once; direction filter keeps in/out apart
   for (genvar g = 0; g < NUM_EP; g++) begin : g_match
      wire dir_ok = (g == 0) ? (i_tok_in ? ep0_tx_en_q : ep0_rx_en_q)
                             : ((g % 2 == 1) == i_tok_in);
      wire adr_ok = addr_hit || ((g == 0) && def_hit);
      // ep0 is always packet-gated, never isochronous
      wire rdy_ok = (g == 0) ? ready_v[g] : (!epc_q[g][EPC_ISO_BIT] || ready_v[g]);
      assign elig[g] = epc_q[g][EPC_EN_BIT] && (epc_q[g][3:0] == i_tok_ep)
                       && dir_ok && adr_ok && rdy_ok;
   end

   // lowest eligible endpoint wins a number clash
   always_comb begin
      pick     = 3'h0;
      pick_hit = 1'b0;
      for (int k = NUM_EP - 1; k >= 0; k--) begin
         if (elig[k]) begin
            pick     = 3'(k);
            pick_hit = 1'b1;
         end
      end
   end

   wire take     = i_tok_valid && running && pick_hit;
   wire ep0_take = take && (pick == 3'h0);

   // selection result and ep0 packet ownership
   always_ff @(posedge i_clk) begin
      if (i_rst || !running) begin
         o_sel_valid  <= 1'b0;
         o_sel_ep     <= 3'h0;
         ep0_rx_act_q <= 1'b0;
         ep0_tx_act_q <= 1'b0;
      end else begin
         o_sel_valid <= take;
         if (take) begin
            o_sel_ep <= pick;
         end
         ep0_rx_act_q <= (ep0_take && !i_tok_in) || (ep0_rx_act_q && !i_rx_end);
         ep0_tx_act_q <= (ep0_take && i_tok_in) || (ep0_tx_act_q && !i_tx_ok && !i_tx_err);
      end
   end

   // ==========================================
   // endpoint zero buffer
   usn_ep0_fifo #(
      .DEPTH (EP0_DEPTH),
      .AW    (3),
      .CW    (4)
   ) u_ep0 (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_clr      (!running || flush),
      .i_clr_done (rd_stat),
      .i_wr       (wr_data),
      .i_wdata    (i_reg_wdata),
      .i_rd       (rd_data),
      .o_rdata    (ep0_rdata),
      .o_count    (ep0_count),
      .o_rx_ready (ep0_rx_ready),
      .o_tx_ready (ep0_tx_ready),
      .o_rx_done  (ep0_rx_done),
      .o_tx_done  (ep0_tx_done),
      .i_rx_valid (i_rx_valid && ep0_rx_act_q),
      .i_rx_data  (i_rx_data),
      .i_rx_end   (i_rx_end && ep0_rx_act_q),
      .i_rx_err   (i_rx_err),
      .i_tx_start (ep0_take && i_tok_in),
      .i_tx_next  (i_tx_next && ep0_tx_act_q),
      .i_tx_ok    (i_tx_ok && ep0_tx_act_q),
      .i_tx_err   (i_tx_err && ep0_tx_act_q),
      .o_tx_valid (o_tx_valid),
      .o_tx_data  (o_tx_data),
      .o_tx_last  (o_tx_last)
   );

   // ==========================================
   // read mux; data stand only in the cycle after the strobe
   wire [7:0] epc_rd  = epc_hit ? epc_q[epc_off[2:0]] : 8'h00;
   wire [7:0] rd_mux  =
      (i_reg_addr == ADR_NODE_STATE) ? {6'h00, node_code} :
      (i_reg_addr == ADR_ALT_EVENT)  ? {3'h0, alternate_event_reg_q} :
      (i_reg_addr == ADR_FUNC_ADDR)  ? {1'b0, function_address_reg_q} :
      (i_reg_addr == ADR_EP0_CMD)    ? {5'h00, ep0_rx_en_q, ep0_tx_en_q, 1'b0} :
      (i_reg_addr == ADR_EP0_STAT)   ? {2'h0, ep0_tx_done, ep0_rx_done, ep0_count} :
      (i_reg_addr == ADR_EP0_DATA)   ? ep0_rdata : epc_rd;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_mux : 8'h00;
      end
   end

   // ==========================================
   // checks
   a_hold_clears_cfg: assert property (@(posedge i_clk) disable iff (i_rst)
      !running |=> function_address_reg_q == 7'h00 && epc_q[0] == 8'h00 && !o_sel_valid) else $error("config kept off");
   a_wake_drives_k: assert property (@(posedge i_clk) disable iff (i_rst)
      node_q == STATE_WAKING |=> o_drive_k) else $error("no resume drive");
   a_susp_low_power: assert property (@(posedge i_clk) disable iff (i_rst)
      node_q == STATE_SUSPENDED |=> o_low_power && !o_drive_k) else $error("suspend output wrong");
   a_write_reset: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_node && i_reg_wdata[1:0] == 2'h0 |=> node_q == STATE_IN_RESET) else $error("no reset");
   a_write_suspend: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_node && i_reg_wdata[1:0] == 2'h3 |=> node_q == STATE_SUSPENDED) else $error("no suspend");
   a_write_run: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_node && i_reg_wdata[1:0] == 2'h2 |=> node_q == STATE_RUNNING) else $error("no run");
   a_write_wake: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_node && i_reg_wdata[1:0] == 2'h1 |=> node_q == STATE_WAKING) else $error("no wake");
   a_event_sticks: assert property (@(posedge i_clk) disable iff (i_rst)
      ev_reset |=> alternate_event_reg_q[EV_RESET] ##1 (alternate_event_reg_q[EV_RESET] || $past(rd_alternate_event_reg))) else $error("flag lost");
   a_addr_miss: assert property (@(posedge i_clk) disable iff (i_rst)
      i_tok_valid && !addr_hit && !def_hit |=> !o_sel_valid) else $error("miss accepted");
   a_low_ep_wins: assert property (@(posedge i_clk) disable iff (i_rst)
      take && elig[1] && elig[3] && !elig[0] |=> o_sel_ep == 3'h1) else $error("higher endpoint chosen");
   a_reset_state: assert property (@(posedge i_clk)
      $past(i_rst) |-> node_q == STATE_IN_RESET) else $error("not reset state");
endmodule

// file: rtl/usn_pkg.sv
// usn_pkg: constants shared by the node state / endpoint dispatch block.
// assumes a single 125 MHz clock domain.
package usn_pkg;
   // ==========================================
   // timing
   localparam int CLK_MHZ      = 125;
   localparam int IDLE3_MS     = 3;
   localparam int IDLE5_MS     = 5;
   localparam int IDLE3_CYC    = IDLE3_MS * CLK_MHZ * 1000;
   localparam int IDLE5_CYC    = IDLE5_MS * CLK_MHZ * 1000;
   localparam int LINE_RST_NS  = 2500;
   localparam int LINE_RST_CYC = (LINE_RST_NS * CLK_MHZ + 999) / 1000;
   localparam int RESUME_NS    = 2500;
   localparam int RESUME_CYC   = (RESUME_NS * CLK_MHZ + 999) / 1000;
   // ==========================================
   // register offsets
   localparam logic [4:0] ADR_NODE_STATE = 5'h00;
   localparam logic [4:0] ADR_ALT_EVENT  = 5'h01;
   localparam logic [4:0] ADR_FUNC_ADDR  = 5'h02;
   localparam logic [4:0] ADR_EP0_CMD    = 5'h03;
   localparam logic [4:0] ADR_EP0_STAT   = 5'h04;
   localparam logic [4:0] ADR_EP0_DATA   = 5'h05;
   localparam logic [4:0] ADR_EP_CTRL    = 5'h08;
   // ==========================================
   // fields and reset values
   localparam int EV_RESET = 0;
   localparam int EV_IDLE3 = 1;
   localparam int EV_IDLE5 = 2;
   localparam int EV_RESUME = 3;
   localparam int EV_EOP   = 4;
   localparam int EPC_EN_BIT  = 4;
   localparam int EPC_ISO_BIT = 5;
   localparam int EPC_DEF_BIT = 6;
   localparam int CMD_FLUSH_BIT = 0;
   localparam int CMD_TX_BIT    = 1;
   localparam int CMD_RX_BIT    = 2;
   localparam logic [7:0] EPC_RST  = 8'h00;
   localparam logic [6:0] FUNCTION_ADDRESS_REG_RST = 7'h00;
   localparam int NUM_EP    = 7;
   localparam int EP0_DEPTH = 8;
   // node state field codes
   localparam logic [1:0] NODE_RESET = 2'h0;
   localparam logic [1:0] NODE_WAKE  = 2'h1;
   localparam logic [1:0] NODE_RUN   = 2'h2;
   localparam logic [1:0] NODE_SUSP  = 2'h3;
   typedef enum logic [3:0] {
      STATE_IN_RESET  = 4'b0001,
      STATE_RUNNING   = 4'b0010,
      STATE_SUSPENDED = 4'b0100,
      STATE_WAKING    = 4'b1000
   } usn_node_t;
endpackage

// file: tb/usn_host_model.sv
// usn_host_model: upstream host line driver for the node dispatch bench.
// assumes mode 0 idle J, 1 SE0, 2 K; the pull-up gives J when idle.
`timescale 1ns/1ps
module usn_host_model (
   // line request from the bench
   input  wire logic [1:0] i_mode,
   // line levels seen by the node
   output logic            o_j,
   output logic            o_se0
);
   // ==========================================
   // line levels; released line rests at J
   assign o_j   = (i_mode == 2'h0);
   assign o_se0 = (i_mode == 2'h1);
endmodule

// file: tb/usn_node_dispatch_tb_top.sv
// usn_node_dispatch_tb_top: self-checking bench, random plus corner cases.
// assumes the host model drives the line pins; short idle counts used.
`timescale 1ns/1ps
module usn_node_dispatch_tb_top import usn_pkg::*; ;
   logic       clk = 0, rst = 1, wr = 0, rd = 0, tv = 0, tin = 0, txe = 0, txo = 0;
   logic       rxv = 0, rxe = 0, rxr = 0;
   logic [4:0] ad = 0;
   logic [7:0] wd = 0, bd = 0;
   logic [6:0] ta = 0, fa = 0;
   logic [3:0] te = 0, n = 0;
   logic [5:0] rdy = 0;
   logic [1:0] mode = 0;
   wire        j, se0, dk, lp, eh, sv, txv, txl;
   wire  [2:0] se;
   wire  [7:0] rq, txd;
   int         failures = 0, comparisons = 0;
   logic [1:0] evm [4] = '{2'h1, 2'h2, 2'h1, 2'h0};
   int         evl [4] = '{330, 330, 10, 80};
   logic [7:0] eve [4] = '{8'h01, 8'h08, 8'h10, 8'h06};
   logic [1:0] stc [5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h0};
   logic [7:0] ste [5] = '{8'h00, 8'h03, 8'h05, 8'h00, 8'h01};
   always #4 clk = ~clk;
   usn_host_model HOST (.i_mode(mode), .o_j(j), .o_se0(se0));
   usn_node_dispatch #(.IDLE3_CYCLES(40), .IDLE5_CYCLES(60)) DUT (
      .i_clk(clk), .i_rst(rst), .i_reg_addr(ad), .i_reg_wdata(wd), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rq), .i_line_j(j), .i_line_se0(se0), .o_drive_k(dk),
      .o_low_power(lp), .o_ep_hold(eh), .i_tok_valid(tv), .i_tok_in(tin), .i_tok_addr(ta),
      .i_tok_ep(te), .i_ep_ready(rdy), .o_sel_valid(sv), .o_sel_ep(se), .i_rx_valid(rxv),
      .i_rx_data(bd), .i_rx_end(rxe), .i_rx_err(rxr), .i_tx_next(1'b0), .i_tx_ok(txo),
      .i_tx_err(txe), .o_tx_valid(txv), .o_tx_data(txd), .o_tx_last(txl));
   // ==========================================
   // shared tasks; every bus signal moves right after a rising edge
   task chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask
   task wrr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk); ad <= a; wd <= d; wr <= 1;
      @(posedge clk); wr <= 0;
   endtask
   // read data stands only in the cycle after the strobe
   task rdc(input logic [4:0] a, input logic [7:0] e);
      @(posedge clk); ad <= a; rd <= 1;
      @(posedge clk); rd <= 0;
      #1 chk(rq, e);
   endtask
   task st(input logic [1:0] c, input logic [7:0] e);
      wrr(ADR_NODE_STATE, {6'h00, c});
      @(posedge clk);
      #1 chk({5'h00, dk, lp, eh}, e);
   endtask
   task tok(input logic i, input logic [6:0] a, input logic [3:0] e);
      @(posedge clk); tv <= 1; tin <= i; ta <= a; te <= e;
      @(posedge clk); tv <= 0;
      #1;
   endtask
   // hold a line condition, go back to J, then check the event flags
   task line(input logic [1:0] m, input int len, input logic [7:0] e);
      mode <= m;
      repeat (len) @(posedge clk);
      mode <= 0;
      repeat (8) @(posedge clk);
      rdc(ADR_ALT_EVENT, e);
   endtask
   // one-byte ep0 out packet; e marks a crc or stuff error
   task pkt(input logic e);
      @(posedge clk);
      rxv <= 1;
      @(posedge clk);
      rxv <= 0;
      rxe <= 1;
      rxr <= e;
      @(posedge clk);
      rxe <= 0;
      rxr <= 0;
   endtask
   task report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // watchdog: a hang counts as a mismatch
   initial begin
      #400000;
      failures++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h0400));
      repeat (10) @(posedge clk);
      rst <= 0;
      #1 chk({5'h00, dk, lp, eh}, 8'h01);
      rdc(ADR_NODE_STATE, 8'h00);
      repeat (80) @(posedge clk);
      rdc(ADR_ALT_EVENT, 8'h06);
      // bus reset, resume K, short eop, then idle again
      for (int k = 0; k < 4; k++) line(evm[k], evl[k], eve[k]);
      // firmware order: suspend and wake on long idle, reset only after a bus reset
      for (int k = 0; k < 5; k++) begin
         if (stc[k] == 2'h0) line(2'h1, 330, 8'h01);
         st(stc[k], ste[k]);
         rdc(ADR_NODE_STATE, {6'h00, stc[k]});
      end
      // resume must still be seen while suspended; suspend only once idle3 is up
      repeat (33) @(posedge clk);
      rdc(ADR_ALT_EVENT, 8'h02);
      wrr(ADR_NODE_STATE, 8'h03);
      line(2'h2, 330, 8'h08);
      // ep1 and ep3 clash on one number, ep2 shares it the other way
      wrr(ADR_NODE_STATE, 8'h02);
      fa = 7'($urandom);
      n = 4'(1 + $urandom % 15);
      rdy <= 6'($urandom) | 6'h15;
      wrr(ADR_FUNC_ADDR, {1'b0, fa});
      for (int k = 0; k < 4; k++) wrr(ADR_EP_CTRL + 5'(k), (k == 0) ? 8'h10 : {4'h1, n});
      tok(1, fa, n); chk({sv, 4'h0, se}, 8'h81);
      tok(0, fa, n); chk({sv, 4'h0, se}, 8'h82);
      tok(1, fa ^ 7'h01, n); chk({sv, 4'h0, se}, 8'h02);
      // ep0 one-byte packet, error, then retry with same data
      bd = 8'($urandom);
      wrr(ADR_EP0_CMD, 8'h02);
      wrr(ADR_EP0_DATA, bd);
      tok(1, fa, 0); chk({sv, 4'h0, se}, 8'h80);
      chk(txd, bd); chk({6'h00, txv, txl}, 8'h03);
      @(posedge clk); txe <= 1;
      @(posedge clk); txe <= 0;
      tok(1, fa, 0); chk(txd, bd); chk({6'h00, txv, txl}, 8'h03);
      // acknowledge frees the buffer and reports tx done
      @(posedge clk);
      txo <= 1;
      @(posedge clk);
      txo <= 0;
      rdc(ADR_EP0_STAT, 8'h20);
      chk({6'h00, txv, txl}, 8'h00);
      // out packets: a bad one vanishes, a clean one is reported, flush empties
      wrr(ADR_EP0_CMD, 8'h05);
      tok(0, fa, 0);
      chk({sv, 4'h0, se}, 8'h80);
      pkt(1);
      rdc(ADR_EP0_STAT, 8'h00);
      bd = ~bd;
      tok(0, fa, 0);
      pkt(0);
      rdc(ADR_EP0_STAT, 8'h11);
      rdc(ADR_EP0_DATA, bd);
      wrr(ADR_EP0_CMD, 8'h05);
      rdc(ADR_EP0_STAT, 8'h00);
      // leaving running clears endpoint setup and refuses tokens
      repeat (60) @(posedge clk);
      line(2'h1, 330, 8'h07);
      wrr(ADR_NODE_STATE, 8'h00);
      rdc(ADR_EP_CTRL + 5'h01, 8'h00);
      tok(1, fa, n); chk({7'h00, sv}, 8'h00);
      report_and_stop;
   end
endmodule
